// File: sbx_pkg.sv
// Shared constants, register map and operation codes for the subtract/inc/dec datapath
package sbx_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] SBX_OFF_CMD    = 8'h00;
  localparam logic [7:0] SBX_OFF_ACC    = 8'h04;
  localparam logic [7:0] SBX_OFF_FLAGS  = 8'h08;
  localparam logic [7:0] SBX_OFF_MPTR   = 8'h0C;
  localparam logic [7:0] SBX_OFF_MDATA  = 8'h10;
  localparam logic [7:0] SBX_OFF_RESULT = 8'h14;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int SBX_CMD_OP_LSB   = 0;
  localparam int SBX_CMD_ADDR_LSB = 8;
  localparam int SBX_FLAG_Z       = 0;
  localparam int SBX_FLAG_C       = 1;
  localparam int SBX_FLAG_AC      = 2;
  localparam int SBX_FLAG_OV      = 3;

  // ==========================================================================
  // Reset values and bus answers
  // ==========================================================================
  localparam logic [7:0] SBX_RST_ACC   = 8'h00;
  localparam logic [3:0] SBX_RST_FLAGS = 4'h0;
  localparam logic [7:0] SBX_RST_MEM   = 8'h00;
  localparam logic [1:0] SBX_RESP_OKAY = 2'h0;
  localparam logic [1:0] SBX_RESP_SLV  = 2'h2;

  // ==========================================================================
  // Operations
  // ==========================================================================
  typedef enum logic [3:0] {
    SBX_OP_NOP,
    SBX_OP_SUB_MA,
    SBX_OP_SUBC_AM,
    SBX_OP_SUBC_MA,
    SBX_OP_SUBC_A,
    SBX_OP_SUBC_M,
    SBX_OP_INC_M,
    SBX_OP_DEC_M,
    SBX_OP_CLR_M
  } sbx_op_t;

endpackage : sbx_pkg

// File: sbx_alu_if.sv
// Operand and result bundle between the core and the adder
interface sbx_alu_if;
  logic [7:0] op_a;
  logic [7:0] op_b;
  logic       cin;
  logic       sub;
  logic [7:0] result;
  logic       zero;
  logic       carry;
  logic       aux_carry;
  logic       overflow;

  modport core (output op_a, output op_b, output cin, output sub,
                input result, input zero, input carry, input aux_carry, input overflow);
  modport alu  (input op_a, input op_b, input cin, input sub,
                output result, output zero, output carry, output aux_carry, output overflow);
endinterface : sbx_alu_if

// File: sbx_alu.sv
// Eight-bit adder with complement path and flag generation
module sbx_alu (
  sbx_alu_if.alu a
);
  logic [7:0] addend;
  logic       cin_eff;
  logic [8:0] sum9;
  logic [4:0] sum5;

  // ==========================================================================
  // Adder
  // ==========================================================================
  always_comb begin
    // RQ2: subtract by complement add
    addend  = a.sub ? ~a.op_b : a.op_b;
    cin_eff = a.sub ? ~a.cin : a.cin;
    sum9    = {1'b0, a.op_a} + {1'b0, addend} + {8'h00, cin_eff};
    sum5    = {1'b0, a.op_a[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin_eff};
  end

  // RQ10: flags from 8-bit result
  // Carry reads as borrow when subtracting
  assign a.result    = sum9[7:0];
  assign a.zero      = (sum9[7:0] == 8'h00);
  assign a.carry     = sum9[8] ^ a.sub;
  assign a.aux_carry = sum5[4] ^ a.sub;
  assign a.overflow  = (a.op_a[7] == addend[7]) && (sum9[7] != a.op_a[7]);

endmodule : sbx_alu

// File: sbx_core.sv
// Accumulator, data memory, flags and AXI4-Lite access for the subtract/inc/dec datapath
// What this block does
// RQ1: memory minus accumulator into memory
// RQ2: subtraction adds two's complement of subtrahend
// RQ3: accumulator minus memory minus carry, to accumulator
// RQ4: memory minus accumulator minus carry, to memory
// RQ5: accumulator minus carry into accumulator
// RQ6: memory minus carry into memory
// RQ7: memory byte incremented in place
// RQ8: memory byte decremented in place
// RQ9: memory byte cleared to zero
// RQ10: flags updated from result; clear keeps flags
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
module sbx_core
  import sbx_pkg::*;
#(
  parameter int MEM_DEPTH = 64
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  localparam int AW = (MEM_DEPTH > 1) ? $clog2(MEM_DEPTH) : 1;

  // ==========================================================================
  // Parameter check
  // ==========================================================================
  generate
    if (MEM_DEPTH < 2 || MEM_DEPTH > 256 || (MEM_DEPTH & (MEM_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("sbx_core: MEM_DEPTH must be a power of two from 2 to 256");
    end
  endgenerate

  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic rst_s1_q;
  logic rst_s2_q;
  logic rst_sync_n;

  // Assert at once, release after two edges
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_sync_n = rst_s2_q;

  // ==========================================================================
  // State
  // ==========================================================================
  logic [7:0]    accumulator_q, accumulator_d;
  logic [3:0]    flags_q, flags_d;
  logic [AW-1:0] mptr_q, mptr_d;
  logic [7:0]    result_q, result_d;
  logic [7:0]    mem_q [MEM_DEPTH];
  logic [7:0]    mem_d [MEM_DEPTH];
  logic          aw_have_q, aw_have_d;
  logic [7:0]    aw_addr_q, aw_addr_d;
  logic          w_have_q, w_have_d;
  logic [31:0]   w_data_q, w_data_d;
  logic [3:0]    w_strb_q, w_strb_d;
  logic          bvalid_q, bvalid_d;
  logic [1:0]    bresp_q, bresp_d;
  logic          rvalid_q, rvalid_d;
  logic [1:0]    rresp_q, rresp_d;
  logic [31:0]   rdata_q, rdata_d;

  sbx_alu_if alu_bus ();

  sbx_alu u_alu (
    .a (alu_bus.alu)
  );

  // ==========================================================================
  // Bus handshake terms
  // ==========================================================================
  logic          aw_fire, w_fire, ar_fire;
  logic          wr_go;
  logic [7:0]    wr_addr;
  logic [31:0]   wr_data;
  logic [3:0]    wr_strb;
  logic          exec;
  sbx_op_t       op;
  logic [AW-1:0] op_addr;
  logic [7:0]    mem_op;
  logic          wr_acc, wr_mem, wr_flg;

  // Ready only while running: a frozen core must not accept
  assign s_axi_awready = ce && !aw_have_q && !bvalid_q;
  assign s_axi_wready  = ce && !w_have_q && !bvalid_q;
  assign s_axi_arready = ce && !rvalid_q;
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire  = s_axi_wvalid && s_axi_wready;
  assign ar_fire = s_axi_arvalid && s_axi_arready;

  // Address and data may arrive in either order
  assign wr_go   = (aw_have_q || aw_fire) && (w_have_q || w_fire);
  assign wr_addr = aw_have_q ? aw_addr_q : s_axi_awaddr;
  assign wr_data = w_have_q ? w_data_q : s_axi_wdata;
  assign wr_strb = w_have_q ? w_strb_q : s_axi_wstrb;

  // Command runs only with both low byte lanes written
  assign exec    = wr_go && (wr_addr == SBX_OFF_CMD) && (wr_strb[1:0] == 2'b11);
  assign op      = exec ? sbx_op_t'(wr_data[SBX_CMD_OP_LSB +: 4]) : SBX_OP_NOP;
  assign op_addr = wr_data[SBX_CMD_ADDR_LSB +: AW];
  assign mem_op  = mem_q[op_addr];

  // ==========================================================================
  // Operand selection
  // ==========================================================================
  always_comb begin
    alu_bus.op_a = mem_op;
    alu_bus.op_b = 8'h00;
    alu_bus.cin  = 1'b0;
    alu_bus.sub  = 1'b1;
    wr_acc       = 1'b0;
    wr_mem       = 1'b0;
    wr_flg       = 1'b1;
    case (op)
      SBX_OP_SUB_MA: begin
        // RQ1: memory minus accumulator
        alu_bus.op_b = accumulator_q;
        wr_mem       = 1'b1;
      end
      SBX_OP_SUBC_AM: begin
        // RQ3: accumulator, memory, borrow
        alu_bus.op_a = accumulator_q;
        alu_bus.op_b = mem_op;
        alu_bus.cin  = flags_q[SBX_FLAG_C];
        wr_acc       = 1'b1;
      end
      SBX_OP_SUBC_MA: begin
        // RQ4: memory, accumulator, borrow
        alu_bus.op_b = accumulator_q;
        alu_bus.cin  = flags_q[SBX_FLAG_C];
        wr_mem       = 1'b1;
      end
      SBX_OP_SUBC_A: begin
        // RQ5: borrow only from accumulator
        alu_bus.op_a = accumulator_q;
        alu_bus.cin  = flags_q[SBX_FLAG_C];
        wr_acc       = 1'b1;
      end
      SBX_OP_SUBC_M: begin
        // RQ6: borrow only from memory
        alu_bus.cin  = flags_q[SBX_FLAG_C];
        wr_mem       = 1'b1;
      end
      SBX_OP_INC_M: begin
        // RQ7: add one in place
        alu_bus.cin  = 1'b1;
        alu_bus.sub  = 1'b0;
        wr_mem       = 1'b1;
      end
      SBX_OP_DEC_M: begin
        // RQ8: subtract one in place
        alu_bus.cin  = 1'b1;
        wr_mem       = 1'b1;
      end
      SBX_OP_CLR_M: begin
        // RQ9: clear, flags untouched
        wr_mem       = 1'b1;
        wr_flg       = 1'b0;
      end
      default: begin
        wr_flg       = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    accumulator_d = accumulator_q;
    flags_d       = flags_q;
    mptr_d        = mptr_q;
    result_d      = result_q;
    mem_d         = mem_q;
    aw_have_d     = aw_have_q;
    aw_addr_d     = aw_addr_q;
    w_have_d      = w_have_q;
    w_data_d      = w_data_q;
    w_strb_d      = w_strb_q;
    bvalid_d      = bvalid_q;
    bresp_d       = bresp_q;
    rvalid_d      = rvalid_q;
    rresp_d       = rresp_q;
    rdata_d       = rdata_q;

    if (aw_fire && !wr_go) begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (w_fire && !wr_go) begin
      w_have_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end

    if (wr_go) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = SBX_RESP_OKAY;
      case (wr_addr)
        SBX_OFF_CMD: begin
        end
        SBX_OFF_ACC: begin
          if (wr_strb[0]) accumulator_d = wr_data[7:0];
        end
        SBX_OFF_FLAGS: begin
          if (wr_strb[0]) flags_d = wr_data[3:0];
        end
        SBX_OFF_MPTR: begin
          if (wr_strb[0]) mptr_d = wr_data[AW-1:0];
        end
        SBX_OFF_MDATA: begin
          if (wr_strb[0]) mem_d[mptr_q] = wr_data[7:0];
        end
        SBX_OFF_RESULT: begin
        end
        default: begin
          bresp_d = SBX_RESP_SLV;
        end
      endcase
      if (wr_acc) accumulator_d = alu_bus.result;
      if (wr_mem) begin
        mem_d[op_addr] = (op == SBX_OP_CLR_M) ? 8'h00 : alu_bus.result;
      end
      if (wr_acc || wr_mem) begin
        result_d = (op == SBX_OP_CLR_M) ? 8'h00 : alu_bus.result;
      end
      // RQ10: flag write-back
      if (wr_flg) begin
        flags_d[SBX_FLAG_Z]  = alu_bus.zero;
        flags_d[SBX_FLAG_C]  = alu_bus.carry;
        flags_d[SBX_FLAG_AC] = alu_bus.aux_carry;
        flags_d[SBX_FLAG_OV] = alu_bus.overflow;
      end
    end
    if (bvalid_q && s_axi_bready) bvalid_d = 1'b0;

    if (ar_fire) begin
      rvalid_d = 1'b1;
      rresp_d  = SBX_RESP_OKAY;
      rdata_d  = 32'h0000_0000;
      case (s_axi_araddr)
        SBX_OFF_CMD:    rdata_d = 32'h0000_0000;
        SBX_OFF_ACC:    rdata_d[7:0] = accumulator_q;
        SBX_OFF_FLAGS:  rdata_d[3:0] = flags_q;
        SBX_OFF_MPTR:   rdata_d[AW-1:0] = mptr_q;
        SBX_OFF_MDATA:  rdata_d[7:0] = mem_q[mptr_q];
        SBX_OFF_RESULT: rdata_d[7:0] = result_q;
        default:        rresp_d = SBX_RESP_SLV;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  // Memory stays out of reset: a real data RAM has no reset either
  always_ff @(posedge clock) begin
    if (ce) mem_q <= mem_d;
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      accumulator_q <= SBX_RST_ACC;
      flags_q       <= SBX_RST_FLAGS;
      mptr_q        <= '0;
      result_q      <= 8'h00;
      aw_have_q     <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_have_q      <= 1'b0;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      bvalid_q      <= 1'b0;
      bresp_q       <= SBX_RESP_OKAY;
      rvalid_q      <= 1'b0;
      rresp_q       <= SBX_RESP_OKAY;
      rdata_q       <= 32'h0000_0000;
    end else if (ce) begin
      accumulator_q <= accumulator_d;
      flags_q       <= flags_d;
      mptr_q        <= mptr_d;
      result_q      <= result_d;
      aw_have_q     <= aw_have_d;
      aw_addr_q     <= aw_addr_d;
      w_have_q      <= w_have_d;
      w_data_q      <= w_data_d;
      w_strb_q      <= w_strb_d;
      bvalid_q      <= bvalid_d;
      bresp_q       <= bresp_d;
      rvalid_q      <= rvalid_d;
      rresp_q       <= rresp_d;
      rdata_q       <= rdata_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp  = rresp_q;
  assign s_axi_rdata  = rdata_q;

endmodule : sbx_core

// File: sbx_core_checker.sv
// Bus-port assertions for the subtract/inc/dec datapath
module sbx_core_checker
  import sbx_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  // ==========================================================================
  // Handshake timing
  // ==========================================================================
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  logic wr_pair;
  logic rd_take;
  assign wr_pair = ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign rd_take = ce && s_axi_arvalid && s_axi_arready;

  AST_WR_ANSWER: assert property (wr_pair |=> s_axi_bvalid) else $error("write answer missing");
  AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  AST_B_DROP: assert property (ce && s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
  AST_B_BLOCKS: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  AST_RD_ANSWER: assert property (rd_take |=> s_axi_rvalid) else $error("read answer missing");
  AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
    && $stable(s_axi_rresp)) else $error("read answer changed");
  AST_AR_READY: assert property (s_axi_arready == (ce && !s_axi_rvalid)) else $error("arready not inverse of rvalid");
  // Unmapped places answer with an error
  AST_BAD_READ: assert property (rd_take && s_axi_araddr > SBX_OFF_RESULT |=> s_axi_rresp == SBX_RESP_SLV
    && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  AST_BAD_WRITE: assert property (wr_pair && s_axi_awaddr > SBX_OFF_RESULT |=> s_axi_bresp == SBX_RESP_SLV)
    else $error("unmapped write not refused");
  AST_CMD_READ: assert property (rd_take && s_axi_araddr == SBX_OFF_CMD |=> s_axi_rdata == 32'h0
    && s_axi_rresp == SBX_RESP_OKAY) else $error("command place reads nonzero");
endmodule : sbx_core_checker

bind sbx_core sbx_core_checker sbx_core_checker_i (.clock(clock), .rst_n(rst_n), .ce(ce),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// File: subtract_incdec_alu_ops_test.sv
// Self-checking bench for the subtract/inc/dec datapath
module subtract_incdec_alu_ops_test
  import sbx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Signals and design
  // ==========================================================================
  logic        clock, rst_n, ce, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [2:0]  prot;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          failures, tests_run, stall;

  sbx_core #(.MEM_DEPTH(16)) sbx_core_i (.clock(clock), .rst_n(rst_n), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awprot(prot), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(prot), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  always #50 clock = ~clock;

  // ==========================================================================
  // Bus and compare tasks
  // ==========================================================================
  task end_sim;
    if (failures == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Answer may be stalled by holding bready low for a while
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (stall == 0);
    for (int n = 1; n < 60; n++) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        return;
      end
      if (n >= stall) bready <= 1'b1;
    end
    failures++;
    $display("Error at %0t: write answer timed out", $time);
    r = 2'h3;
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (stall == 0);
    for (int n = 1; n < 60; n++) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        return;
      end
      if (n >= stall) rready <= 1'b1;
    end
    failures++;
    $display("Error at %0t: read answer timed out", $time);
    r = 2'h3;
  endtask : rd

  task wr_ok(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, 4'hF, r);
    chk({30'h0, r}, {30'h0, SBX_RESP_OKAY});
  endtask : wr_ok

  task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, exp);
    chk({30'h0, r}, {30'h0, er});
  endtask : rd_chk

  // ==========================================================================
  // Reference arithmetic: flags {OV, AC, C, Z} above the result
  // ==========================================================================
  function automatic logic [11:0] sub8(input logic [7:0] x, input logic [7:0] y, input logic b);
    logic [8:0] d;
    logic [4:0] h;
    d = {1'b0, x} - {1'b0, y} - b;
    h = {1'b0, x[3:0]} - {1'b0, y[3:0]} - b;
    return {(x[7] != y[7]) && (d[7] != x[7]), h[4], d[8], d[7:0] == 8'h00, d[7:0]};
  endfunction : sub8

  // Loads operands, runs one command, reads every visible result back
  task do_op(input sbx_op_t op, input logic [7:0] a, input logic [7:0] m, input logic c, input logic [7:0] p);
    logic [11:0] e;
    logic [7:0]  ea, em;
    ea = a;
    em = m;
    case (op)
      SBX_OP_SUB_MA:  e = sub8(m, a, 1'b0);
      SBX_OP_SUBC_AM: e = sub8(a, m, c);
      SBX_OP_SUBC_MA: e = sub8(m, a, c);
      SBX_OP_SUBC_A:  e = sub8(a, 8'h00, c);
      SBX_OP_SUBC_M:  e = sub8(m, 8'h00, c);
      SBX_OP_INC_M:   e = {m == 8'h7F, m[3:0] == 4'hF, m == 8'hFF, m == 8'hFF, m + 8'h01};
      SBX_OP_DEC_M:   e = {m == 8'h80, m[3:0] == 4'h0, m == 8'h00, m == 8'h01, m - 8'h01};
      default:        e = {2'b00, c, 1'b0, 8'h00};
    endcase
    if (op == SBX_OP_SUBC_AM || op == SBX_OP_SUBC_A) ea = e[7:0];
    else em = e[7:0];
    wr_ok(SBX_OFF_MPTR, {24'h0, p});
    wr_ok(SBX_OFF_MDATA, {24'h0, m});
    wr_ok(SBX_OFF_ACC, {24'h0, a});
    wr_ok(SBX_OFF_FLAGS, {30'h0, c, 1'b0});
    wr_ok(SBX_OFF_CMD, {16'h0, p, 4'h0, op});
    rd_chk(SBX_OFF_ACC, {24'h0, ea}, SBX_RESP_OKAY);
    rd_chk(SBX_OFF_MDATA, {24'h0, em}, SBX_RESP_OKAY);
    rd_chk(SBX_OFF_FLAGS, {28'h0, e[11:8]}, SBX_RESP_OKAY);
    rd_chk(SBX_OFF_RESULT, {24'h0, e[7:0]}, SBX_RESP_OKAY);
  endtask : do_op

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task sc_reset;
    rd_chk(SBX_OFF_MPTR, 32'h0, SBX_RESP_OKAY);
    rd_chk(SBX_OFF_ACC, 32'h0, SBX_RESP_OKAY);
    rd_chk(SBX_OFF_FLAGS, 32'h0, SBX_RESP_OKAY);
    rd_chk(SBX_OFF_RESULT, 32'h0, SBX_RESP_OKAY);
  endtask : sc_reset

  task sc_sub;
    logic [7:0] va [4] = '{8'h05, 8'h01, 8'h07, 8'h01};
    logic [7:0] vm [4] = '{8'h03, 8'h80, 8'h07, 8'h10};
    for (int i = 0; i < 4; i++) do_op(SBX_OP_SUB_MA, va[i], vm[i], i[0], 8'(i));
  endtask : sc_sub

  task sc_subc;
    sbx_op_t ops [4] = '{SBX_OP_SUBC_AM, SBX_OP_SUBC_MA, SBX_OP_SUBC_A, SBX_OP_SUBC_M};
    for (int i = 0; i < 8; i++) do_op(ops[i % 4], 8'h80, 8'h01, i[2], 8'h0F);
    do_op(SBX_OP_SUBC_AM, 8'h00, 8'h00, 1'b1, 8'h02);
  endtask : sc_subc

  task sc_incdec;
    logic [7:0] vm [6] = '{8'hFF, 8'h7F, 8'h0F, 8'h00, 8'h80, 8'h01};
    for (int i = 0; i < 6; i++) do_op(SBX_OP_INC_M, 8'h33, vm[i], 1'b0, 8'h0F);
    for (int i = 0; i < 6; i++) do_op(SBX_OP_DEC_M, 8'h33, vm[i], 1'b1, 8'h0E);
  endtask : sc_incdec

  task sc_clear;
    do_op(SBX_OP_CLR_M, 8'h55, 8'hAA, 1'b1, 8'h03);
    // Undefined code must leave flags and memory alone
    wr_ok(SBX_OFF_CMD, {16'h0, 8'h03, 4'h0, 4'h9});
    rd_chk(SBX_OFF_FLAGS, 32'h2, SBX_RESP_OKAY);
    rd_chk(SBX_OFF_MDATA, 32'h0, SBX_RESP_OKAY);
  endtask : sc_clear

  // Stalled answers, unmapped places, command without full strobe
  task sc_bus;
    logic [1:0] r;
    stall = 3;
    wr(8'h20, 32'h1, 4'hF, r);
    chk({30'h0, r}, {30'h0, SBX_RESP_SLV});
    rd_chk(8'h18, 32'h0, SBX_RESP_SLV);
    rd_chk(SBX_OFF_CMD, 32'h0, SBX_RESP_OKAY);
    stall = 0;
    wr(SBX_OFF_CMD, {16'h0, 8'h03, 4'h0, SBX_OP_INC_M}, 4'h1, r);
    chk({30'h0, r}, {30'h0, SBX_RESP_OKAY});
    rd_chk(SBX_OFF_MDATA, 32'h0, SBX_RESP_OKAY);
  endtask : sc_bus

  // Clock enable low: nothing taken, nothing answered
  task sc_hold;
    ce <= 1'b0;
    fork
      wr_ok(SBX_OFF_ACC, 32'h0000_005A);
      begin
        repeat (4) @(posedge clock);
        chk({31'h0, awready}, 32'h0);
        chk({31'h0, bvalid}, 32'h0);
        ce <= 1'b1;
      end
    join
    rd_chk(SBX_OFF_ACC, 32'h0000_005A, SBX_RESP_OKAY);
  endtask : sc_hold

  // ==========================================================================
  // Main sequence and watchdog
  // ==========================================================================
  initial begin
    {clock, rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb, prot} = '0;
    ce = 1'b1;
    failures = 0;
    tests_run = 0;
    stall = 0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    sc_reset;
    sc_sub;
    sc_subc;
    sc_incdec;
    sc_clear;
    sc_bus;
    sc_hold;
    end_sim;
  end

  // Whole run needs under a thousand cycles
  initial begin
    #(100 * 20000);
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim;
  end
endmodule : subtract_incdec_alu_ops_test
